/* File: design/dfc_ctrl_map.vh */
// constants for the dual fifo reset, retransmit and byte-order control
`ifndef DFC_CTRL_MAP_VH
`define DFC_CTRL_MAP_VH
// write-clock cycles from reset release to input-ready high
`define DFC_READY_DELAY 2'h2
// flag-select capture layout {sel2, sel1, sel0}
`define DFC_FS_W 3
`define DFC_FS_RST 3'h0
// synchroniser lanes, one per pin from outside the clock
`define DFC_LANES 9
`define DFC_LANE_F1_MRST 0
`define DFC_LANE_F2_MRST 1
`define DFC_LANE_F1_PRST 2
`define DFC_LANE_F2_PRST 3
`define DFC_LANE_MODE 4
`define DFC_LANE_ORDER 5
`define DFC_LANE_FSEL 6
// offset register reset value
`define DFC_OFS_RST 13'h0000
// pointer first location
`define DFC_PTR_FIRST 13'h0000
`endif

/* File: design/dfc_sync.v */
// three-stage synchroniser for an asynchronous active-low pin
`timescale 1ns/1ps
module dfc_sync (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // pin and clean level
  input wire i_pin_n,
  output wire o_level_n
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg out_reg;
  // ==========================================================
  // stages; a change counts once the second and third agree
  // resets to the asserted level, so leaving i_reset ends like a master reset
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg <= i_pin_n;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        out_reg <= s3_reg;
      end
    end
  end
  assign o_level_n = out_reg;
endmodule // dfc_sync

/* File: design/dfc_ctrl.v */
// reset, retransmit and byte-order control for a two-fifo buffer
// Notes on behaviour
// R1 - controller pulses both master resets after power-up
// R2 - fifo1 master reset held four edges
// R3 - fifo2 master reset held four edges
// R4 - master reset pins synchronised internally
// R5 - master reset clears pointers and sets flags
// R6 - input ready rises two write cycles later
// R7 - fifo1 reset release captures order and selects
// R8 - fifo2 reset release clears its offsets
// R9 - joint release captures fifo2 settings too
// R10 - controller keeps port c mailbox high
// R11 - partial reset held four edges each
// R12 - retransmit mode low during partial reset
// R13 - partial reset pins synchronised internally
// R14 - partial reset clears pointers and sets flags
// R15 - partial reset keeps offsets, method, timing
// R16 - fifo1 retransmit rewinds fifo1 read pointer
// R17 - controller holds fifo2 retransmit four edges
// R18 - fifo2 retransmit rewinds fifo2 read pointer
// R19 - mode select splits retransmit from partial reset
// R20 - big endian: msb part goes first
// R21 - little endian: lsb part goes first
// R22 - first edge after release picks timing mode
`timescale 1ns/1ps
`include "dfc_ctrl_map.vh"
module dfc_ctrl #(
  parameter PTR_W = 13
) (
  // clock and reset; port clocks run in phase with i_clk here
  input wire i_clk,
  input wire i_reset,
  // asynchronous control pins
  input wire i_fifo1_master_reset_n,
  input wire i_fifo2_master_reset_n,
  input wire i_fifo1_partial_reset_n,
  input wire i_fifo2_partial_reset_n,
  input wire i_retransmit_mode_sel,
  input wire i_byte_order_timing_sel,
  input wire i_flag_sel0,
  input wire i_flag_sel1,
  input wire i_flag_sel2,
  // offsets from the programming logic
  input wire i_ofs_load,
  input wire [PTR_W-1:0] i_fifo2_almost_empty_offset,
  input wire [PTR_W-1:0] i_fifo2_almost_full_offset,
  // flags and pointer resets
  output wire o_porta_full_in_ready,
  output wire o_portc_full_in_ready,
  output wire o_porta_empty_out_ready,
  output wire o_portb_empty_out_ready,
  output wire o_porta_almost_empty_n,
  output wire o_portb_almost_empty_n,
  output wire o_porta_almost_full_n,
  output wire o_portc_almost_full_n,
  output wire o_mailbox1_flag_n,
  output wire o_mailbox2_flag_n,
  output wire o_fifo1_ptr_clear,
  output wire o_fifo2_ptr_clear,
  output wire o_fifo1_read_rewind,
  output wire o_fifo2_read_rewind,
  output wire [PTR_W-1:0] o_fifo1_first_loc,
  output wire [PTR_W-1:0] o_fifo2_first_loc,
  // captured configuration
  output wire o_big_endian_sel,
  output wire [`DFC_FS_W-1:0] o_flag_sel,
  output wire [`DFC_FS_W-1:0] o_fifo2_flag_sel,
  output wire o_fifo1_fall_through_mode,
  output wire o_fifo2_fall_through_mode,
  output wire [PTR_W-1:0] o_fifo2_ae_offset,
  output wire [PTR_W-1:0] o_fifo2_af_offset
);
  // ==========================================================
  // synchronised pins
  // every pin from outside this clock passes the same three stages, so the
  // order and flag selects line up in time with the reset edges that take them
  wire [`DFC_LANES-1:0] raw_n;
  wire [`DFC_LANES-1:0] sync_n;
  assign raw_n = {i_flag_sel2, i_flag_sel1, i_flag_sel0, i_byte_order_timing_sel,
    i_retransmit_mode_sel, i_fifo2_partial_reset_n, i_fifo1_partial_reset_n,
    i_fifo2_master_reset_n, i_fifo1_master_reset_n};
  genvar g;
  generate
    for (g = 0; g < `DFC_LANES; g = g + 1) begin : g_sync
      // asynchronous edges never reach the flag logic raw
      dfc_sync u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin_n(raw_n[g]),
        .o_level_n(sync_n[g])
      ); // R4 R13
    end
  endgenerate
  wire f1_mreset_n = sync_n[`DFC_LANE_F1_MRST];
  wire f2_mreset_n = sync_n[`DFC_LANE_F2_MRST];
  wire rewind_mode = sync_n[`DFC_LANE_MODE];
  wire order_sel = sync_n[`DFC_LANE_ORDER];
  wire [`DFC_FS_W-1:0] fsel = sync_n[`DFC_LANE_FSEL +: `DFC_FS_W];
  // shared pin is partial reset when mode low, retransmit when high
  wire f1_preset = ~sync_n[`DFC_LANE_F1_PRST] & ~rewind_mode; // R19
  wire f2_preset = ~sync_n[`DFC_LANE_F2_PRST] & ~rewind_mode; // R19
  wire f1_rewind = ~sync_n[`DFC_LANE_F1_PRST] & rewind_mode; // R19
  wire f2_rewind = ~sync_n[`DFC_LANE_F2_PRST] & rewind_mode; // R19
  wire rst1 = ~f1_mreset_n | f1_preset;
  wire rst2 = ~f2_mreset_n | f2_preset;
  // ==========================================================
  // state
  reg f1_mreset_d_reg;
  reg f2_mreset_d_reg;
  reg [1:0] cnt1_reg;
  reg [1:0] cnt2_reg;
  reg ready1_reg;
  reg ready2_reg;
  reg order_reg;
  reg [`DFC_FS_W-1:0] fs_reg;
  reg [`DFC_FS_W-1:0] fs2_reg;
  reg tsamp1_reg;
  reg tsamp2_reg;
  reg fall1_reg;
  reg fall2_reg;
  reg [PTR_W-1:0] ae_ofs_reg;
  reg [PTR_W-1:0] af_ofs_reg;
  // release edges of the synchronised master resets
  wire rise1 = f1_mreset_n & ~f1_mreset_d_reg;
  wire rise2 = f2_mreset_n & ~f2_mreset_d_reg;
  // ==========================================================
  // reset release counters for input ready
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      f1_mreset_d_reg <= 1'b0;
      f2_mreset_d_reg <= 1'b0;
      cnt1_reg <= 2'h0;
      cnt2_reg <= 2'h0;
      ready1_reg <= 1'b0;
      ready2_reg <= 1'b0;
    end else begin
      f1_mreset_d_reg <= f1_mreset_n;
      f2_mreset_d_reg <= f2_mreset_n;
      if (rst1) begin
        cnt1_reg <= 2'h0; // R5 R14
        ready1_reg <= 1'b0; // R5 R14
      end else if (!ready1_reg) begin
        cnt1_reg <= cnt1_reg + 2'h1;
        ready1_reg <= (cnt1_reg + 2'h1) == `DFC_READY_DELAY; // R6
      end
      if (rst2) begin
        cnt2_reg <= 2'h0; // R5 R14
        ready2_reg <= 1'b0; // R5 R14
      end else if (!ready2_reg) begin
        cnt2_reg <= cnt2_reg + 2'h1;
        ready2_reg <= (cnt2_reg + 2'h1) == `DFC_READY_DELAY; // R6
      end
    end
  end
  // ==========================================================
  // configuration capture; partial reset never touches it
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      order_reg <= 1'b0;
      fs_reg <= `DFC_FS_RST;
      fs2_reg <= `DFC_FS_RST;
      tsamp1_reg <= 1'b0;
      tsamp2_reg <= 1'b0;
      fall1_reg <= 1'b0;
      fall2_reg <= 1'b0;
      ae_ofs_reg <= `DFC_OFS_RST;
      af_ofs_reg <= `DFC_OFS_RST;
    end else begin
      // selects come through the same stages as the reset, so they match its edge
      if (rise1) begin
        order_reg <= order_sel; // R7
        fs_reg <= fsel; // R7
      end
      // fifo2 keeps its own flag choice, taken only on a joint release
      if (rise1 && rise2) begin
        fs2_reg <= fsel; // R9
      end
      if (!f1_mreset_n) begin
        tsamp1_reg <= 1'b0;
      end else if (!tsamp1_reg) begin
        tsamp1_reg <= 1'b1;
        fall1_reg <= ~order_sel; // R22
      end
      if (!f2_mreset_n) begin
        tsamp2_reg <= 1'b0;
      end else if (!tsamp2_reg) begin
        tsamp2_reg <= 1'b1;
        fall2_reg <= ~order_sel; // R22
      end
      // a release clear wins over a load in the same cycle
      if (rise2) begin
        ae_ofs_reg <= `DFC_OFS_RST; // R8
        af_ofs_reg <= `DFC_OFS_RST; // R8
      end else if (i_ofs_load) begin
        ae_ofs_reg <= i_fifo2_almost_empty_offset; // R15
        af_ofs_reg <= i_fifo2_almost_full_offset; // R15
      end
    end
  end
  // ==========================================================
  // flag outputs; each forced during its own fifo's reset
  // ready is masked at once when a reset starts; the register alone lags a cycle
  assign o_porta_full_in_ready = ready1_reg & ~rst1; // R5 R6
  assign o_portc_full_in_ready = ready2_reg & ~rst2; // R5 R6
  assign o_portb_empty_out_ready = 1'b0 & ~rst1; // R5 R14
  assign o_porta_empty_out_ready = 1'b0 & ~rst2; // R5 R14
  assign o_portb_almost_empty_n = 1'b0; // R5 R14
  assign o_porta_almost_empty_n = 1'b0; // R5 R14
  assign o_porta_almost_full_n = 1'b1; // R5 R14
  assign o_portc_almost_full_n = 1'b1; // R5 R14
  assign o_mailbox1_flag_n = 1'b1; // R5 R14
  assign o_mailbox2_flag_n = 1'b1; // R5 R14
  assign o_fifo1_ptr_clear = rst1; // R5 R14
  assign o_fifo2_ptr_clear = rst2; // R5 R14
  // a retransmit is ignored while the master reset is still low
  assign o_fifo1_read_rewind = f1_rewind & f1_mreset_n; // R16
  assign o_fifo2_read_rewind = f2_rewind & f2_mreset_n; // R18
  assign o_fifo1_first_loc = `DFC_PTR_FIRST;
  assign o_fifo2_first_loc = `DFC_PTR_FIRST;
  // big endian sends msb part first, little endian lsb first
  assign o_big_endian_sel = order_reg; // R20 R21
  assign o_flag_sel = fs_reg;
  assign o_fifo2_flag_sel = fs2_reg; // R9
  assign o_fifo1_fall_through_mode = fall1_reg;
  assign o_fifo2_fall_through_mode = fall2_reg;
  assign o_fifo2_ae_offset = ae_ofs_reg;
  assign o_fifo2_af_offset = af_ofs_reg;
endmodule // dfc_ctrl

/* File: verification/dfc_ctrl_assertions.sv */
// checker for the reset and retransmit control
`timescale 1ns/1ps
module dfc_ctrl_checker #(parameter PTR_W = 13) (
  input wire i_clk, input wire i_reset,
  input wire i_fifo1_master_reset_n, input wire i_fifo2_master_reset_n,
  input wire i_retransmit_mode_sel,
  input wire o_porta_full_in_ready, input wire o_portc_full_in_ready,
  input wire o_portb_empty_out_ready, input wire o_portb_almost_empty_n,
  input wire o_porta_almost_full_n, input wire o_mailbox1_flag_n,
  input wire o_fifo1_ptr_clear, input wire o_fifo2_ptr_clear,
  input wire o_fifo1_read_rewind, input wire o_fifo2_read_rewind,
  input wire o_big_endian_sel, input wire [2:0] o_flag_sel);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // cycles with both master resets high; config must settle by then
  reg [3:0] hi_cnt;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) hi_cnt <= 4'h0;
    else if (!(i_fifo1_master_reset_n && i_fifo2_master_reset_n)) hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
  end
  property p_clr1; o_fifo1_ptr_clear |-> !o_porta_full_in_ready && !o_portb_empty_out_ready
    && !o_portb_almost_empty_n && o_porta_almost_full_n && o_mailbox1_flag_n; endproperty
  a_clr1: assert property (p_clr1) else $error("fifo1 flags wrong in reset");
  property p_clr2; o_fifo2_ptr_clear |-> !o_portc_full_in_ready; endproperty
  a_clr2: assert property (p_clr2) else $error("fifo2 ready high in reset");
  property p_rdy1;
    $fell(o_fifo1_ptr_clear) |-> !o_porta_full_in_ready ##[1:3] o_porta_full_in_ready;
  endproperty
  a_rdy1: assert property (p_rdy1) else $error("port a ready late");
  property p_rdy2;
    $fell(o_fifo2_ptr_clear) |-> !o_portc_full_in_ready ##[1:3] o_portc_full_in_ready;
  endproperty
  a_rdy2: assert property (p_rdy2) else $error("port c ready late");
  property p_sync; !i_fifo1_master_reset_n [*5] |-> o_fifo1_ptr_clear; endproperty
  a_sync: assert property (p_sync) else $error("master reset not seen");
  property p_keep; hi_cnt > 4'h8 |-> $stable({o_big_endian_sel, o_flag_sel}); endproperty
  a_keep: assert property (p_keep) else $error("config moved");
  property p_rt1;
    $rose(o_fifo1_read_rewind) |-> i_retransmit_mode_sel && !o_fifo1_ptr_clear;
  endproperty
  a_rt1: assert property (p_rt1) else $error("bad fifo1 rewind");
  property p_rt2;
    $rose(o_fifo2_read_rewind) |-> i_retransmit_mode_sel && !o_fifo2_ptr_clear;
  endproperty
  a_rt2: assert property (p_rt2) else $error("bad fifo2 rewind");
  c_rdy: cover property ($rose(o_portc_full_in_ready));
  c_rt1: cover property ($rose(o_fifo1_read_rewind));
  c_rt2: cover property ($rose(o_fifo2_read_rewind));
endmodule // dfc_ctrl_checker
bind dfc_ctrl dfc_ctrl_checker #(.PTR_W(PTR_W)) u_chk (.*);

/* File: verification/dfc_host.sv */
// model of the controller driving the reset and retransmit pins
`timescale 1ns/1ps
module dfc_host #(parameter HOLD = 6) (
  input wire i_clk, input wire i_start, input wire [2:0] i_kind,
  output reg o_f1_mreset_n, output reg o_f2_mreset_n, output reg o_f1_preset_n,
  output reg o_f2_preset_n, output reg o_mode, output wire o_busy,
  output wire o_portc_mailbox_sel);
  reg [4:0] cnt = 5'h0;
  reg [2:0] k = 3'h0;
  assign o_busy = cnt != 5'h0;
  // port c mailbox select never drops, so it is high through every master reset
  assign o_portc_mailbox_sel = 1'h1;
  initial {o_f1_mreset_n, o_f2_mreset_n, o_f1_preset_n, o_f2_preset_n, o_mode} = 5'h1E;
  // kinds: 0 both master, 1/2 partial, 3/4 retransmit; mode set before the pulse
  always @(posedge i_clk) begin
    if (i_start && cnt == 5'h0) begin
      cnt <= 5'h1;
      k <= i_kind;
      o_mode <= i_kind > 3'h2;
    end else if (cnt != 5'h0) cnt <= (cnt == 5'h14) ? 5'h0 : cnt + 5'h1;
    // pin low for HOLD edges, more than the four needed
    if (cnt == 5'h1) begin
      o_f1_mreset_n <= k != 3'h0;
      o_f2_mreset_n <= k != 3'h0;
      o_f1_preset_n <= k != 3'h1 && k != 3'h3;
      o_f2_preset_n <= k != 3'h2 && k != 3'h4;
    end
    if (cnt == 5'h1 + HOLD) begin
      {o_f1_mreset_n, o_f2_mreset_n, o_f1_preset_n, o_f2_preset_n} <= 4'hF;
    end
    if (cnt == 5'h14) o_mode <= 1'h0; // mode outlasts the synchroniser delay
  end
endmodule // dfc_host

/* File: verification/dfc_ctrl_test.sv */
// self-checking bench for the reset and retransmit control
`timescale 1ns/1ps
module dfc_ctrl_test;
  reg i_clk = 1'h0, i_reset = 1'h1, start = 1'h0, ld = 1'h0, bsel = 1'h0, pc = 1'h0;
  reg [2:0] kind = 3'h0, fs = 3'h0;
  reg [1:0] pr = 2'h0;
  reg [12:0] ae = 13'h0, af = 13'h0;
  reg [31:0] rs = 32'h72396BFE, cyc = 0, n_mismatch = 0, checks_done = 0;
  reg [34:0] qc[$];
  reg [3:0] qr[$];
  wire m1, m2, p1, p2, md, busy, rc, w1, w2, c1, c2, bo, f1, f2;
  wire [2:0] fso, fso2;
  wire [12:0] aeo, afo;
  dfc_host host (.i_clk(i_clk), .i_start(start), .i_kind(kind), .o_f1_mreset_n(m1),
    .o_f2_mreset_n(m2), .o_f1_preset_n(p1), .o_f2_preset_n(p2), .o_mode(md), .o_busy(busy),
    .o_portc_mailbox_sel());
  dfc_ctrl dut (.i_clk(i_clk), .i_reset(i_reset), .i_fifo1_master_reset_n(m1),
    .i_fifo2_master_reset_n(m2), .i_fifo1_partial_reset_n(p1), .i_fifo2_partial_reset_n(p2),
    .i_retransmit_mode_sel(md), .i_byte_order_timing_sel(bsel), .i_flag_sel0(fs[0]),
    .i_flag_sel1(fs[1]), .i_flag_sel2(fs[2]), .i_ofs_load(ld), .i_fifo2_almost_empty_offset(ae),
    .i_fifo2_almost_full_offset(af), .o_porta_full_in_ready(), .o_portc_full_in_ready(rc),
    .o_porta_empty_out_ready(), .o_portb_empty_out_ready(), .o_porta_almost_empty_n(),
    .o_portb_almost_empty_n(), .o_porta_almost_full_n(), .o_portc_almost_full_n(),
    .o_mailbox1_flag_n(), .o_mailbox2_flag_n(), .o_fifo1_ptr_clear(c1), .o_fifo2_ptr_clear(c2),
    .o_fifo1_read_rewind(w1), .o_fifo2_read_rewind(w2), .o_fifo1_first_loc(),
    .o_fifo2_first_loc(), .o_big_endian_sel(bo), .o_flag_sel(fso), .o_fifo2_flag_sel(fso2),
    .o_fifo1_fall_through_mode(f1), .o_fifo2_fall_through_mode(f2), .o_fifo2_ae_offset(aeo),
    .o_fifo2_af_offset(afo));
  initial forever #5 i_clk = ~i_clk;
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task cmp_cfg(input [34:0] got);
    reg [34:0] e;
    begin
      e = qc.size() ? qc.pop_front() : ~got;
      checks_done = checks_done + 1;
      if (got !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %0t config %h", $time, got);
      end
    end
  endtask
  task cmp_rt(input [3:0] got);
    reg [3:0] e;
    begin
      e = qr.size() ? qr.pop_front() : ~got;
      checks_done = checks_done + 1;
      if (got !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %0t rewind %h", $time, got);
      end
    end
  endtask
  task test_done;
    begin
      if (qc.size() || qr.size()) n_mismatch = n_mismatch + 1;
      if (n_mismatch == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // watcher: outputs settle by the falling edge, so rises are taken there
  always @(negedge i_clk) begin
    // config word: fifo2 selects, order, selects, both timing modes, fifo2 offsets
    if (rc === 1'h1 && !pc)
      cmp_cfg({fso2, bo, fso, f1, f2, aeo, afo});
    if ({w1, w2} != 2'h0 && {w1, w2} != pr) cmp_rt({w1, w2, c1, c2});
    pc = rc;
    pr = {w1, w2};
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  task op(input [2:0] k);
    begin
      @(posedge i_clk); #1 kind = k; start = 1'h1;
      @(posedge i_clk); #1 start = 1'h0;
      while (busy) @(posedge i_clk);
      repeat (4) @(posedge i_clk);
      #1;
    end
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    #1 i_reset = 1'h0;
    // leaving i_reset ends a master reset of both fifos with every select low
    qc.push_back({3'h0, 1'h0, 3'h0, 2'h3, 26'h0});
    repeat (12) @(posedge i_clk);
    #1;
    repeat (4) begin
      rs = xs(rs);
      bsel = rs[0];
      fs = rs[3:1];
      qc.push_back({fs, bsel, fs, ~bsel, ~bsel, 26'h0});
      op(3'h0);
      rs = xs(rs);
      @(posedge i_clk); #1 ae = rs[12:0]; af = rs[25:13]; ld = 1'h1;
      @(posedge i_clk); #1 ld = 1'h0; fs = ~fs;
      qc.push_back({~fs, bsel, ~fs, ~bsel, ~bsel, ae, af});
      op(3'h2);
      qr.push_back(4'h8);
      op(3'h3);
      qr.push_back(4'h4);
      op(3'h4);
      op(3'h1);
    end
    test_done;
  end
endmodule // dfc_ctrl_test
